// >>> logic/usf_regs.vh
// register offsets, field positions, reset values and codes of the serial status block
`ifndef USF_REGS_VH
`define USF_REGS_VH
`define USF_ADDR_W        4
`define USF_OFF_CFGH      4'h0
`define USF_OFF_STAL      4'h1
`define USF_OFF_STAH      4'h2
`define USF_OFF_CTRL      4'h3
`define USF_OFF_TXDATA    4'h4
`define USF_OFF_RXDATA    4'h5
`define USF_OFF_PARAM1    4'h6
`define USF_OFF_PARAM2    4'h7
`define USF_CFGH_TXINV    2
`define USF_CFGH_STOP_BITS_SELECT_LO 4
`define USF_STAH_TX_WRITE_ERROR    7
`define USF_STAH_STOP_DETECT_MODE    6
`define USF_STAH_TXBE     5
`define USF_STAH_TXBF     4
`define USF_STAH_RX_LINE_IDLE    3
`define USF_STAH_XON      2
`define USF_STAH_RXBE     1
`define USF_STAH_RXBF     0
`define USF_STAL_RST      16'h0080
`define USF_STAH_RST      16'h002A
`define USF_FLO_NONE      2'h0
`define USF_FLO_SW        2'h1
`define USF_FLO_HW        2'h2
`define USF_MOD_7BIT      4'h1
`define USF_MOD_ODD       4'h2
`define USF_MOD_EVEN      4'h3
`define USF_MOD_ADDR      4'h4
`define USF_XON_CHAR      8'h11
`define USF_XOFF_CHAR     8'h13
`endif

// >>> logic/usf_fifo.v
// eight-entry fifo with occupancy count and pointer reset
module usf_fifo #(
  parameter W     = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         core_clk_in,
  input  wire         sys_rst_in,
  input  wire         flush_in,
  input  wire         push_in,
  input  wire [W-1:0] push_data_in,
  input  wire         pop_in,
  output wire [W-1:0] head_out,
  output wire [AW:0]  count_out
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   count_r;
  wire do_push = push_in && (count_r != DEPTH[AW:0]);
  wire do_pop  = pop_in && (count_r != {(AW+1){1'b0}});
  assign head_out  = mem[rd_ptr_r];
  assign count_out = count_r;
  always @(posedge core_clk_in) begin
    if (do_push && !flush_in) begin
      mem[wr_ptr_r] <= push_data_in;
    end
  end
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // usf_fifo

// >>> logic/usf_sticky.v
// bank of hardware-set, software-cleared sticky flags
module usf_sticky #(
  parameter N = 6
) (
  input  wire         core_clk_in,
  input  wire         sys_rst_in,
  input  wire [N-1:0] set_in,
  input  wire [N-1:0] clr_in,
  output wire [N-1:0] flag_out
);
  reg [N-1:0] flag_r;
  assign flag_out = flag_r;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          flag_r[i] <= 1'b0;
        end else if (set_in[i]) begin
          flag_r[i] <= 1'b1; // set wins over a clear in the same cycle
        end else if (clr_in[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // usf_sticky

// >>> logic/usf_status.v
// status, error flag and interrupt selection logic of the serial port
//
// Overview of operation
// - transmit polarity bit inverts line output
// - flow select: 10 hardware, 01 software, 00 none
// - upper status byte holds eight interrupt enables
// - shifter empty flag, timing set by stop mode
// - bit 6 parity error or address received
// - auto-baud overflow sticky, software clears
// - checksum error sticky until software clears
// - framing flag follows head receive character
// - break received sets sticky flag
// - character into full receive fifo sets overflow
// - transmit collision sets sticky flag
// - transmit threshold by free slots
// - receive threshold by occupancy
// - parity/framing enabled errors block receive watermark
// - write errors set transmit write error flag
// - receive flag timing follows stop mode
// - writing one with transmit off flushes fifo
// - transmit full status mirrors fifo full
// - receive idle status, resets to one
// - mode field selects character format
// - xon status in software flow mode
// - writing one with receive off flushes fifo
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "usf_regs.vh"
module usf_status #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire        core_clk_in,
  input  wire        sys_rst_in,
  input  wire [3:0]  addr_in,
  input  wire [15:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [15:0] rdata_out,
  input  wire        tx_serial_in,
  output reg         tx_line_out,
  input  wire        rx_line_busy_in,
  input  wire        rx_char_valid_in,
  input  wire [8:0]  rx_char_in,
  input  wire        rx_stop_level_in,
  input  wire        rx_parity_err_in,
  input  wire        rx_break_in,
  input  wire        rx_stop_mid_in,
  input  wire        rx_stop_end_in,
  input  wire        tx_stop_mid_in,
  input  wire        tx_stop_end_in,
  input  wire        tx_shift_load_in,
  input  wire        tx_pop_in,
  input  wire        tx_word_done_in,
  input  wire [8:0]  tx_word_in,
  input  wire [8:0]  rx_echo_word_in,
  input  wire        autobaud_active_in,
  input  wire        baud_rollover_in,
  input  wire        checksum_bad_in,
  input  wire        cts_in,
  output reg  [8:0]  tx_head_out,
  output reg         tx_avail_out,
  output reg         rts_out,
  output reg         tx_hold_out,
  output reg         tx_irq_out,
  output reg         rx_irq_out,
  output reg  [7:0]  event_irq_out
);
  reg  [15:0] cfgh_r;
  reg  [7:0]  irq_en_r;
  reg  [5:0]  sth_sel_r;
  reg         stop_detect_mode_r;
  reg  [5:0]  ctrl_r;
  reg  [8:0]  param1_r;
  reg         param1_full_r;
  reg  [8:0]  param2_r;
  reg         shifter_empty_r;
  reg         xon_r;
  reg         rx_flag_r;
  wire [3:0]  mode       = ctrl_r[3:0];
  wire        tx_en      = ctrl_r[4];
  wire        rx_en      = ctrl_r[5];
  wire [1:0]  flow_ctrl_select        = cfgh_r[1:0];
  wire        tx_inv     = cfgh_r[`USF_CFGH_TXINV];
  wire        stsel2     = (cfgh_r[5:4] == 2'h2);

  function [3:0] cnt_lo4;
    input [AW:0] c;
    cnt_lo4 = c[3:0];
  endfunction

  wire wr_cfgh  = wr_in && addr_in == `USF_OFF_CFGH;
  wire wr_stal  = wr_in && addr_in == `USF_OFF_STAL;
  wire wr_stah  = wr_in && addr_in == `USF_OFF_STAH;
  wire wr_tx    = wr_in && addr_in == `USF_OFF_TXDATA;
  wire wr_p1    = wr_in && addr_in == `USF_OFF_PARAM1;
  wire rd_rx    = rd_in && addr_in == `USF_OFF_RXDATA;

  wire [9:0]  tx_head;
  wire [AW:0] tx_cnt;
  wire [9:0]  rx_head;
  wire [AW:0] rx_cnt;
  wire tx_full  = (tx_cnt == DEPTH[AW:0]);
  wire rx_full  = (rx_cnt == DEPTH[AW:0]);
  wire tx_empty = (tx_cnt == {(AW+1){1'b0}});
  wire rx_empty = (rx_cnt == {(AW+1){1'b0}});
  wire tx_flush = wr_stah && wdata_in[`USF_STAH_TXBE] && !tx_en;
  wire rx_flush = wr_stah && wdata_in[`USF_STAH_RXBE] && !rx_en;
  wire rx_push  = rx_char_valid_in && rx_en && !rx_full;

  usf_fifo #(.W(10), .DEPTH(DEPTH), .AW(AW)) u_txq (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .flush_in     (tx_flush),
    .push_in      (wr_tx),
    .push_data_in ({1'b0, wdata_in[8:0]}),
    .pop_in       (tx_pop_in),
    .head_out     (tx_head),
    .count_out    (tx_cnt)
  );

  // framing status travels with each stored character
  usf_fifo #(.W(10), .DEPTH(DEPTH), .AW(AW)) u_rxq (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .flush_in     (rx_flush),
    .push_in      (rx_push),
    .push_data_in ({~rx_stop_level_in, rx_char_in}),
    .pop_in       (rd_rx),
    .head_out     (rx_head),
    .count_out    (rx_cnt)
  );

  wire framing_flag = !rx_empty && rx_head[9];
  wire parity_mode  = (mode == `USF_MOD_ODD) || (mode == `USF_MOD_EVEN) || mode[3];
  wire addr_mode    = (mode == `USF_MOD_ADDR);
  wire addr_seen    = addr_mode && rx_push && rx_char_in[8];
  wire parity_set   = (parity_mode && rx_push && rx_parity_err_in) || addr_seen;
  wire collide      = tx_word_done_in && (tx_word_in != rx_echo_word_in);
  wire wr_err       = wr_tx && tx_full
                    || wr_tx && parity_mode && param2_r == 9'h000
                    || wr_p1 && addr_mode && param1_full_r;

  // sticky order: tx_write_error, parity, autobaud_ovf_flag, checksum_err_flag, rx_break_flag, rx_overflow_flag, tx_collision_flag
  wire [6:0] st_set = {wr_err, parity_set, autobaud_active_in && baud_rollover_in,
                       checksum_bad_in, rx_break_in,
                       rx_char_valid_in && rx_en && rx_full, collide};
  wire [6:0] st_clr = {wr_stah && !wdata_in[`USF_STAH_TX_WRITE_ERROR],
                       wr_stal && !wdata_in[6], wr_stal && !wdata_in[5],
                       wr_stal && !wdata_in[4], wr_stal && !wdata_in[2],
                       wr_stal && !wdata_in[1], wr_stal && !wdata_in[0]};
  wire [6:0] st_flag;
  usf_sticky #(.N(7)) u_sticky (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .set_in       (st_set),
    .clr_in       (st_clr),
    .flag_out     (st_flag)
  );

  wire [7:0] sta_low = {shifter_empty_r, st_flag[5], st_flag[4], st_flag[3],
                        framing_flag, st_flag[2], st_flag[1], st_flag[0]};
  wire [15:0] stal_word = {irq_en_r, sta_low};
  wire [15:0] stah_word = {1'b0, sth_sel_r[5:3], 1'b0, sth_sel_r[2:0],
                           st_flag[6], stop_detect_mode_r, tx_empty, tx_full,
                           !rx_line_busy_in, xon_r, rx_empty, rx_full};

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfgh_r        <= 16'h0000;
      irq_en_r      <= 8'h00;
      sth_sel_r     <= 6'h00;
      stop_detect_mode_r       <= 1'b0;
      ctrl_r        <= 6'h00;
      param1_r      <= 9'h000;
      param1_full_r <= 1'b0;
      param2_r      <= 9'h000;
    end else begin
      if (wr_cfgh) begin
        cfgh_r <= wdata_in & 16'h8FFF;
      end
      if (wr_stal) begin
        irq_en_r <= wdata_in[15:8];
      end
      if (wr_stah) begin
        sth_sel_r <= {wdata_in[14:12], wdata_in[10:8]};
        stop_detect_mode_r   <= wdata_in[`USF_STAH_STOP_DETECT_MODE];
      end
      if (wr_in && addr_in == `USF_OFF_CTRL) begin
        ctrl_r <= wdata_in[5:0];
      end
      if (wr_p1 && !(addr_mode && param1_full_r)) begin
        param1_r      <= wdata_in[8:0];
        param1_full_r <= 1'b1;
      end else if (tx_shift_load_in) begin
        param1_full_r <= 1'b0;
      end
      if (wr_in && addr_in == `USF_OFF_PARAM2) begin
        param2_r <= wdata_in[8:0];
      end
    end
  end

  // shifter empty and receive flag timing
  wire tx_done_evt = stop_detect_mode_r ? tx_stop_end_in : tx_stop_mid_in;
  wire rx_done_evt = stop_detect_mode_r ? rx_stop_end_in : rx_stop_mid_in;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shifter_empty_r <= 1'b1;
      rx_flag_r       <= 1'b0;
      xon_r           <= 1'b0;
    end else begin
      if (tx_shift_load_in) begin
        shifter_empty_r <= 1'b0;
      end else if (tx_done_evt) begin
        shifter_empty_r <= 1'b1;
      end
      rx_flag_r <= rx_done_evt && rx_en;
      if (flow_ctrl_select == `USF_FLO_SW && !mode[3] && rx_push) begin
        if (rx_char_in[7:0] == `USF_XON_CHAR) begin
          xon_r <= 1'b1;
        end else if (rx_char_in[7:0] == `USF_XOFF_CHAR) begin
          xon_r <= 1'b0;
        end
      end
    end
  end

  // watermarks
  wire [3:0] tx_free   = DEPTH[3:0] - cnt_lo4(tx_cnt);
  wire       tx_wm     = tx_free >= (4'h8 - {1'b0, sth_sel_r[5:3]});
  wire       rx_wm     = cnt_lo4(rx_cnt) >= ({1'b0, sth_sel_r[2:0]} + 4'h1);
  wire       rx_block  = (st_flag[5] && irq_en_r[6]) || (framing_flag && irq_en_r[3]);
  wire [7:0] ev_flags  = {shifter_empty_r, st_flag[5], st_flag[4], st_flag[3],
                          framing_flag, st_flag[2], st_flag[1], st_flag[0]};
  wire       sw_flow   = (flow_ctrl_select == `USF_FLO_SW) && !mode[3];
  wire       hw_flow   = (flow_ctrl_select == `USF_FLO_HW) && !mode[3];
  wire       tx_active = !tx_empty && tx_en;
  wire       flow_ok   = hw_flow ? !cts_in : (sw_flow ? xon_r : 1'b1);

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out     <= 16'h0000;
      tx_line_out   <= 1'b1;
      tx_head_out   <= 9'h000;
      tx_avail_out  <= 1'b0;
      rts_out       <= 1'b1;
      tx_hold_out   <= 1'b0;
      tx_irq_out    <= 1'b0;
      rx_irq_out    <= 1'b0;
      event_irq_out <= 8'h00;
    end else begin
      tx_line_out   <= tx_serial_in ^ tx_inv;
      tx_head_out   <= (mode == `USF_MOD_7BIT) ? {2'b00, tx_head[6:0]} : tx_head[8:0];
      tx_avail_out  <= tx_active;
      tx_hold_out   <= !flow_ok;
      rts_out       <= hw_flow ? rx_full : 1'b0;
      tx_irq_out    <= tx_wm && tx_en;
      rx_irq_out    <= rx_wm && !rx_block && rx_flag_r;
      event_irq_out <= ev_flags & irq_en_r;
      if (rd_in) begin
        case (addr_in)
          `USF_OFF_CFGH:   rdata_out <= cfgh_r;
          `USF_OFF_STAL:   rdata_out <= stal_word;
          `USF_OFF_STAH:   rdata_out <= stah_word;
          `USF_OFF_CTRL:   rdata_out <= {10'h000, ctrl_r};
          `USF_OFF_RXDATA: rdata_out <= {8'h00, rx_head[7:0]};
          `USF_OFF_PARAM1: rdata_out <= {7'h00, param1_r};
          `USF_OFF_PARAM2: rdata_out <= {7'h00, param2_r};
          default:         rdata_out <= 16'h0000;
        endcase
      end else begin
        rdata_out <= 16'h0000;
      end
    end
  end
endmodule // usf_status

// >>> verif/usf_status_properties.sv
// assertion checker on the ports of the serial status block
module usf_status_properties (
  input wire        core_clk_in,
  input wire        sys_rst_in,
  input wire [3:0]  addr_in,
  input wire [15:0] wdata_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [15:0] rdata_out,
  input wire        tx_serial_in,
  input wire        tx_line_out,
  input wire        rx_line_busy_in,
  input wire        rx_stop_mid_in,
  input wire        rx_stop_end_in,
  input wire        rx_irq_out,
  input wire [7:0]  event_irq_out
);
  reg  inv_r;
  wire cfg_wr = wr_in && (addr_in == 4'h0);
  // shadow of the polarity bit
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) inv_r <= 1'b0;
    else if (cfg_wr) inv_r <= wdata_in[2];
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_rd_at(logic [3:0] a);
    rd_in && (addr_in == a);
  endsequence
  sequence s_idle_steady;
    $stable(rx_line_busy_in);
  endsequence
  a_line_polarity: assert property (!cfg_wr |=> tx_line_out == ($past(tx_serial_in) ^ inv_r))
    else $error("tx line polarity wrong");
  a_read_idle_zero: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (rd_in && addr_in[3] |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_event_and_en: assert property (s_rd_at(4'h1) |=> event_irq_out == (rdata_out[7:0] & rdata_out[15:8]))
    else $error("event request not flag and enable");
  a_tx_buf_excl: assert property (s_rd_at(4'h2) |=> !(rdata_out[5] && rdata_out[4]))
    else $error("tx empty and full together");
  a_rx_buf_excl: assert property (s_rd_at(4'h2) |=> !(rdata_out[1] && rdata_out[0]))
    else $error("rx empty and full together");
  a_rx_idle_lvl: assert property (s_rd_at(4'h2) ##0 s_idle_steady |=> rdata_out[3] == !$past(rx_line_busy_in))
    else $error("rx idle status wrong");
  a_rx_irq_cause: assert property (rx_irq_out |-> $past(rx_stop_mid_in || rx_stop_end_in, 2))
    else $error("rx irq without stop event");
endmodule // usf_status_properties

bind usf_status usf_status_properties u_props (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tx_serial_in(tx_serial_in),
  .tx_line_out(tx_line_out), .rx_line_busy_in(rx_line_busy_in), .rx_stop_mid_in(rx_stop_mid_in),
  .rx_stop_end_in(rx_stop_end_in), .rx_irq_out(rx_irq_out), .event_irq_out(event_irq_out)
);

// >>> verif/usf_remote_model.sv
// remote transceiver model delivering received characters
module usf_remote_model (
  input  wire       core_clk_in,
  output reg        rx_busy_out,
  output reg        rx_valid_out,
  output reg  [8:0] rx_char_out,
  output reg        rx_stop_out,
  output reg        rx_parity_or_addr_flag_out,
  output reg        cts_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_busy_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_char_out = 9'h155;
    rx_stop_out = 1'b1;
    rx_parity_or_addr_flag_out = 1'b0;
    cts_out = 1'b0;
  end
  // len sets how slowly the character arrives
  task send_char(input [8:0] ch, input stop, input parity_or_addr_flag, input int len);
    rx_busy_out <= 1'b1;
    repeat (len) @(posedge core_clk_in);
    rx_valid_out <= 1'b1;
    rx_char_out <= ch;
    rx_stop_out <= stop;
    rx_parity_or_addr_flag_out <= parity_or_addr_flag;
    @(posedge core_clk_in);
    rx_valid_out <= 1'b0;
    rx_busy_out <= 1'b0;
    // stale lines show inverted values
    rx_char_out <= ~ch;
    rx_stop_out <= ~stop;
    rx_parity_or_addr_flag_out <= ~parity_or_addr_flag;
  endtask
endmodule // usf_remote_model

// >>> verif/usf_status_test.sv
// self-checking testbench of the serial status block
`include "usf_regs.vh"
module usf_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg         clk, rst, wr, rd, ser, smid, send, tmid, tend, tload, wdone, abact, broll, ckbad, brk;
  reg  [3:0]  addr;
  reg  [15:0] wdata, rv;
  reg  [8:0]  tw [0:7];
  reg  [8:0]  q [0:7];
  wire        rbusy, rval, rstp, rper, cts, txl, tav, rts, hold, tirq, rirq;
  wire [8:0]  rch, thead;
  wire [15:0] rdata;
  wire [7:0]  evi;
  int         err_count, comparisons, cyc, i, j, k;
  int         bp [4] = '{5, 4, 2, 0};
  usf_remote_model m (.core_clk_in(clk), .rx_busy_out(rbusy), .rx_valid_out(rval), .rx_char_out(rch),
    .rx_stop_out(rstp), .rx_parity_or_addr_flag_out(rper), .cts_out(cts));
  usf_status dut (.core_clk_in(clk), .sys_rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .tx_serial_in(ser), .tx_line_out(txl), .rx_line_busy_in(rbusy),
    .rx_char_valid_in(rval), .rx_char_in(rch), .rx_stop_level_in(rstp), .rx_parity_err_in(rper),
    .rx_break_in(brk), .rx_stop_mid_in(smid), .rx_stop_end_in(send), .tx_stop_mid_in(tmid),
    .tx_stop_end_in(tend), .tx_shift_load_in(tload), .tx_pop_in(1'b0), .tx_word_done_in(wdone),
    .tx_word_in(9'h0AA), .rx_echo_word_in(9'h055), .autobaud_active_in(abact), .baud_rollover_in(broll),
    .checksum_bad_in(ckbad), .cts_in(cts), .tx_head_out(thead), .tx_avail_out(tav), .rts_out(rts),
    .tx_hold_out(hold), .tx_irq_out(tirq), .rx_irq_out(rirq), .event_irq_out(evi));
  initial begin
    {clk, wr, rd, ser, smid, send, tmid, tend, tload, wdone, abact, broll, ckbad, brk} = 0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
  end
  always #50 clk = ~clk;
  always @(posedge clk) ser <= $urandom;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task chk(input [15:0] g, input [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // one-cycle pulse on an event input
  task ev(input int n);
    @(posedge clk);
    case (n)
      0: smid <= 1'b1;
      1: send <= 1'b1;
      2: tmid <= 1'b1;
      3: tend <= 1'b1;
      4: tload <= 1'b1;
      5: broll <= 1'b1;
      6: ckbad <= 1'b1;
      7: brk <= 1'b1;
      default: wdone <= 1'b1;
    endcase
    @(posedge clk);
    {smid, send, tmid, tend, tload, broll, ckbad, brk, wdone} <= 0;
    #1;
  endtask
  task complete_run;
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(46));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h1); chk(rv, 16'h0080);
    rd_reg(4'h2); chk(rv, 16'h002A);
    for (i = 8; i < 16; i++) begin
      rd_reg(i[3:0]); chk(rv, 16'h0000);
    end
    j = $urandom;
    wr_reg(4'h1, {j[7:0], 8'h00});
    rd_reg(4'h1); chk({8'h00, rv[15:8]}, {8'h00, j[7:0]});
    wr_reg(4'h1, 16'hFF00);
    for (j = 0; j < 2; j++) begin
      wr_reg(4'h2, j ? 16'h0040 : 16'h0000);
      ev(4); ev(j ? 2 : 3);
      rd_reg(4'h1); chk1(rv[7], 1'b0);
      ev(j ? 3 : 2);
      rd_reg(4'h1); chk1(rv[7], 1'b1);
    end
    wr_reg(4'h3, 16'h0010);
    for (i = 0; i <= 8; i++) begin
      for (j = 0; j < 8; j++) begin
        wr_reg(4'h2, {1'b0, j[2:0], 12'h000});
        repeat (2) @(posedge clk);
        #1 chk1(tirq, (8 - i) >= (8 - j));
      end
      rd_reg(4'h2); chk1(rv[5], i == 0);
      chk1(rv[4], i == 8);
      chk1(tav, i != 0);
      if (i < 8) begin
        tw[i] = $urandom;
        wr_reg(4'h4, {7'h00, tw[i]});
      end
    end
    chk({7'h00, thead}, {7'h00, tw[0]});
    wr_reg(4'h4, 16'h01FF);
    rd_reg(4'h2); chk1(rv[7], 1'b1);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h2, 16'h0020);
    rd_reg(4'h2); chk(rv, 16'h002A);
    wr_reg(4'h3, 16'h0020);
    wr_reg(4'h0, 16'h0006);
    for (i = 1; i <= 9; i++) begin
      k = $urandom;
      if (i == 1) k[8] = 1'b1; // clean head character, watermark not blocked
      m.send_char({1'b0, k[7:0]}, k[8], 1'b0, 1 + k[10:9]);
      if (i == 9) begin
        rd_reg(4'h1); chk1(rv[1], 1'b1);
      end else begin
        tw[i - 1] = k[8];
        q[i - 1] = {1'b0, k[7:0]};
        repeat (2) @(posedge clk);
        #1 chk1(rts, i == 8);
        for (j = 0; j < 8; j++) begin
          wr_reg(4'h2, {5'h00, j[2:0], 8'h00});
          ev(1);
          @(posedge clk);
          #1 chk1(rirq, 1'b0);
          ev(0);
          @(posedge clk);
          #1 chk1(rirq, i >= j + 1);
        end
      end
    end
    for (i = 0; i < 8; i++) begin
      rd_reg(4'h1); chk1(rv[3], ~tw[i][0]);
      rd_reg(4'h5); chk(rv, {7'h00, q[i]});
    end
    m.send_char(9'h033, 1'b1, 1'b0, 1);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h2, 16'h0002);
    rd_reg(4'h2); chk(rv, 16'h002A);
    abact <= 1'b1;
    for (k = 0; k < 4; k++) begin
      ev(5 + k);
      wr_reg(4'h1, 16'hFFFF);
      rd_reg(4'h1); chk1(rv[bp[k]], 1'b1);
      wr_reg(4'h1, 16'hFF00);
      rd_reg(4'h1); chk1(rv[bp[k]], 1'b0);
    end
    wr_reg(4'h0, 16'h0001);
    wr_reg(4'h3, 16'h0020);
    m.send_char({1'b0, `USF_XON_CHAR}, 1'b1, 1'b0, 2);
    rd_reg(4'h2); chk1(rv[2], 1'b1);
    chk1(hold, 1'b0);
    m.send_char({1'b0, `USF_XOFF_CHAR}, 1'b1, 1'b0, 1);
    rd_reg(4'h2); chk1(rv[2], 1'b0);
    chk1(hold, 1'b1);
    wr_reg(4'h3, 16'h0022);
    m.send_char(9'h041, 1'b1, 1'b1, 2);
    rd_reg(4'h1); chk1(rv[6], 1'b1);
    ev(0);
    @(posedge clk);
    #1 chk1(rirq, 1'b0);
    wr_reg(4'h1, 16'h0000);
    ev(0);
    @(posedge clk);
    #1 chk1(rirq, 1'b1);
    complete_run();
  end
endmodule // usf_status_test
